/* File: pkg/cctd_pkg.sv */
// Contract
// - Prefetch queue overlaps next fetch, shortening time
// - Each memory wait state lengthens execution
// - ROM fast count only when fetch bit set
// - Fast RAM window follows relocation page 0/F
// - Other RAM, external, special areas use slow counts
// - Word on 8-bit or odd address adds 4
// - Internal RAM 16-bit; odd ROM word adds 4
// - Odd stack word raises per-register coefficient 4
// - Three-byte on 8-bit or odd adds 4
// - Short encoding short count, long encoding long
// - Operand byte is repeat count for table/MAC
// - C register repeat count; suspension stretches time
// - Shift time scales with bit count
// - Push/pop time scales with register count
// - Pin check reads twice, XORs, sets zero
// - Accumulator pin check also stores XOR in A
// - Bank select: 00000101 then 10101 plus bank
// - Alternate bank select: same byte, then 10111
package cctd_pkg;

  localparam int CCTD_AW = 8;

  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_MM    = 8'h04;
  localparam logic [7:0] OFF_LOC   = 8'h08;
  localparam logic [7:0] OFF_OPC   = 8'h0c;
  localparam logic [7:0] OFF_ADDR  = 8'h10;
  localparam logic [7:0] OFF_ATTR  = 8'h14;
  localparam logic [7:0] OFF_BASES = 8'h18;
  localparam logic [7:0] OFF_BASEL = 8'h1c;
  localparam logic [7:0] OFF_CREG  = 8'h20;
  localparam logic [7:0] OFF_STAT  = 8'h24;
  localparam logic [7:0] OFF_TOTAL = 8'h28;

  localparam int CTRL_ISSUE_BIT = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int MM_FAST_BIT    = 7;

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [7:0]  RST_MM   = 8'h80;

  localparam logic [7:0] OP_SELBANK = 8'h05;
  localparam logic [4:0] SEL_MAIN   = 5'h15;
  localparam logic [4:0] SEL_ALT    = 5'h17;
  localparam logic [7:0] OP_SWAPSET = 8'hfc;
  localparam logic [7:0] OP_PREFIX7 = 8'h07;
  localparam logic [7:0] OP_PINCHK  = 8'hc8;
  localparam logic [7:0] OP_PINACC  = 8'hc9;
  localparam logic [7:0] OP_STRING  = 8'h15;
  localparam logic [7:0] OP_INT_ON  = 8'h4b;
  localparam logic [7:0] OP_INT_OFF = 8'h4a;

  localparam logic [3:0]  PAGE_LOW   = 4'h0;
  localparam logic [3:0]  PAGE_HIGH  = 4'hf;
  localparam logic [23:0] IRAM0_LO   = 24'h00fd00;
  localparam logic [23:0] IRAM0_HI   = 24'h00feff;
  localparam logic [23:0] IRAMF_LO   = 24'h0ffd00;
  localparam logic [23:0] IRAMF_HI   = 24'h0ffeff;
  localparam logic [23:0] ROM_TOP    = 24'h010000;

  localparam logic [3:0] PEN_CLK = 4'h4;

  typedef enum logic [1:0] {
    SZ_BYTE   = 2'h0,
    SZ_WORD   = 2'h1,
    SZ_TRIPLE = 2'h2,
    SZ_NONE   = 2'h3
  } cctd_size_e;

  typedef enum logic [1:0] {
    NC_OPERAND = 2'h0,
    NC_CREG    = 2'h1,
    NC_SHIFT   = 2'h2,
    NC_STACK   = 2'h3
  } cctd_ncls_e;

  typedef struct packed {
    logic [7:0] operand;
    logic [7:0] coef;
    logic [7:0] waits;
    logic       sfr;
    logic       branch;
    cctd_ncls_e nclass;
    logic       long_enc;
    logic       bus8;
    cctd_size_e size;
  } cctd_attr_s;

  typedef struct packed {
    logic       rbsel;
    logic       alternate_set_variant;
    logic [2:0] bank;
    logic       swap_register_set_op;
    logic       pin_chk;
    logic       pin_acc;
    logic       strop;
    logic       ints_on;
    logic       ints_off;
  } cctd_dec_s;

endpackage : cctd_pkg

/* File: rtl/cctd_decode.sv */
`timescale 1ns/1ps
module cctd_decode (
  input  wire logic [7:0]        b1_i,
  input  wire logic [7:0]        b2_i,
  output cctd_pkg::cctd_dec_s    dec_o
);
  import cctd_pkg::*;

  wire is_sel = (b1_i == OP_SELBANK);
  wire is_p7  = (b1_i == OP_PREFIX7);

  assign dec_o.rbsel    = is_sel & (b2_i[7:3] == SEL_MAIN);
  assign dec_o.alternate_set_variant      = is_sel & (b2_i[7:3] == SEL_ALT);
  assign dec_o.bank     = b2_i[2:0];
  assign dec_o.swap_register_set_op     = is_sel & (b2_i == OP_SWAPSET);
  assign dec_o.pin_chk  = is_p7 & (b2_i == OP_PINCHK);
  assign dec_o.pin_acc  = is_p7 & (b2_i == OP_PINACC);
  assign dec_o.strop    = (b1_i == OP_STRING);
  assign dec_o.ints_on  = (b1_i == OP_INT_ON);
  assign dec_o.ints_off = (b1_i == OP_INT_OFF);

endmodule : cctd_decode

/* File: rtl/cctd_region.sv */
`timescale 1ns/1ps
module cctd_region (
  input  wire logic [23:0] addr_i,
  input  wire logic [3:0]  page_i,
  input  wire logic        sfr_i,
  output logic             is_rom_o,
  output logic             is_fast_internal_ram_o
);
  import cctd_pkg::*;

  // Any page other than 0H or 0FH leaves no fast window
  wire in0 = (addr_i >= IRAM0_LO) & (addr_i <= IRAM0_HI);
  wire inf = (addr_i >= IRAMF_LO) & (addr_i <= IRAMF_HI);
  wire w0  = (page_i == PAGE_LOW) & in0;
  wire wf  = (page_i == PAGE_HIGH) & inf;

  assign is_fast_internal_ram_o = ~sfr_i & (w0 | wf);
  assign is_rom_o  = ~sfr_i & ~is_fast_internal_ram_o & (addr_i < ROM_TOP);

endmodule : cctd_region

/* File: rtl/cctd_top.sv */
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module cctd_top (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [cctd_pkg::CCTD_AW-1:0] wb_adr_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic [31:0]                       wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic [7:0]                   pins_i,
  input  wire logic                         suspend_i,
  output logic [2:0]                        bank_o,
  output logic                              alt_set_o,
  output logic                              zero_flag_o,
  output logic [7:0]                        acc_o,
  output logic                              busy_o,
  output logic                              done_o,
  output logic                              int_enable_o
);
  import cctd_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PIN1 = 4'b0010,
    ST_PIN2 = 4'b0100,
    ST_RUN  = 4'b1000
  } cctd_state_e;

  cctd_state_e state_r;
  cctd_state_e state_nxt;

  logic        ack_r;
  logic [31:0] dat_r;
  logic [7:0]  mm_r;
  logic [3:0]  loc_r;
  logic [15:0] opc_r;
  logic [23:0] addr_r;
  cctd_attr_s  attr_r;
  logic [23:0] bases_r;
  logic [23:0] basel_r;
  logic [15:0] creg_r;
  logic [17:0] total_r;
  logic [17:0] remain_r;
  logic        prev_branch_r;
  logic        pin_acc_r;
  logic [7:0]  samp1_r;
  logic [7:0]  pins_m_r;
  logic [7:0]  pins_s_r;
  logic        susp_m_r;
  logic        susp_s_r;
  logic [2:0]  bank_r;
  logic        alt_r;
  logic        zero_r;
  logic [7:0]  acc_r;
  logic        done_r;
  logic        inten_r;

  // Bus decode
  logic [31:0] wmask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wmask[8*gi +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  wire req    = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr_en  = req & wb_we_i;
  wire hit_ct = wr_en & (wb_adr_i == OFF_CTRL);
  wire hit_mm = wr_en & (wb_adr_i == OFF_MM);
  wire hit_lc = wr_en & (wb_adr_i == OFF_LOC);
  wire hit_op = wr_en & (wb_adr_i == OFF_OPC);
  wire hit_ad = wr_en & (wb_adr_i == OFF_ADDR);
  wire hit_at = wr_en & (wb_adr_i == OFF_ATTR);
  wire hit_bs = wr_en & (wb_adr_i == OFF_BASES);
  wire hit_bl = wr_en & (wb_adr_i == OFF_BASEL);
  wire hit_cr = wr_en & (wb_adr_i == OFF_CREG);
  wire hit_st = wr_en & (wb_adr_i == OFF_STAT);

  wire idle     = (state_r == ST_IDLE);
  // An issue while busy is dropped; software polls busy first
  wire issue    = hit_ct & wb_sel_i[0] & wb_dat_i[CTRL_ISSUE_BIT] & idle;
  wire clr_done = hit_st & wb_sel_i[0] & wb_dat_i[STAT_DONE_BIT];
  wire [31:0] wdat = wb_dat_i & wmask;

  // Instruction decode and region classification
  cctd_dec_s dec;
  logic      is_rom;
  logic      is_fast_internal_ram;

  cctd_decode u_dec (
    .b1_i  (opc_r[15:8]),
    .b2_i  (opc_r[7:0]),
    .dec_o (dec)
  );

  cctd_region u_reg (
    .addr_i    (addr_r),
    .page_i    (loc_r),
    .sfr_i     (attr_r.sfr),
    .is_rom_o  (is_rom),
    .is_fast_internal_ram_o (is_fast_internal_ram)
  );

  // Clock count assembly
  wire col_rom  = is_rom & mm_r[MM_FAST_BIT];
  wire col_fast_internal_ram = is_fast_internal_ram;
  wire col_gen  = ~col_rom & ~col_fast_internal_ram;
  wire odd      = addr_r[0];
  wire is_word  = (attr_r.size == SZ_WORD);
  wire is_tri   = (attr_r.size == SZ_TRIPLE);
  wire [23:0] base_tab = attr_r.long_enc ? basel_r : bases_r;
  wire [7:0]  base = col_rom  ? base_tab[7:0] :
                     col_fast_internal_ram ? base_tab[15:8] : base_tab[23:16];
  wire gen_pen  = col_gen & (attr_r.bus8 | odd);
  wire pen_hit  = (is_word & gen_pen)
                | (is_tri & gen_pen)
                | (is_word & col_rom & odd);
  wire [3:0] pen = pen_hit ? PEN_CLK : 4'h0;
  wire stk_odd  = (attr_r.nclass == NC_STACK) & odd & is_word;
  // Operand byte serves table/MAC repeats, shift width and register count
  wire [7:0] n_cnt = (attr_r.nclass == NC_CREG) ? creg_r[7:0]
                                                : attr_r.operand;
  wire [8:0]  coef  = {1'b0, attr_r.coef} + (stk_odd ? {5'h00, PEN_CLK} : 9'h000);
  wire [16:0] nterm = 17'(coef) * 17'(n_cnt);
  wire [17:0] raw   = 18'(base) + 18'(pen) + 18'(nterm) + 18'(attr_r.waits);
  wire [17:0] credit = prev_branch_r ? 18'h0 : 18'(creg_r[15:8]);
  wire [17:0] total = (raw > credit + 18'h1) ? raw - credit : 18'h1;

  wire pin_op  = dec.pin_chk | dec.pin_acc;
  wire [7:0] pin_x = samp1_r ^ pins_s_r;

  // Read mux
  wire [31:0] stat = {16'h0000, acc_r, inten_r, bank_r, alt_r, zero_r, done_r, ~idle};
  wire [31:0] rd_data =
    (wb_adr_i == OFF_CTRL)  ? 32'h0 :
    (wb_adr_i == OFF_MM)    ? {24'h0, mm_r} :
    (wb_adr_i == OFF_LOC)   ? {28'h0, loc_r} :
    (wb_adr_i == OFF_OPC)   ? {16'h0, opc_r} :
    (wb_adr_i == OFF_ADDR)  ? {8'h0, addr_r} :
    (wb_adr_i == OFF_ATTR)  ? 32'(attr_r) :
    (wb_adr_i == OFF_BASES) ? {8'h0, bases_r} :
    (wb_adr_i == OFF_BASEL) ? {8'h0, basel_r} :
    (wb_adr_i == OFF_CREG)  ? {16'h0, creg_r} :
    (wb_adr_i == OFF_STAT)  ? stat :
    (wb_adr_i == OFF_TOTAL) ? {14'h0, total_r} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= RST_ZERO;
    end
    else
    begin
      ack_r <= req;
      dat_r <= req ? rd_data : dat_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mm_r    <= RST_MM;
      loc_r   <= RST_ZERO[3:0];
      opc_r   <= RST_ZERO[15:0];
      addr_r  <= RST_ZERO[23:0];
      attr_r  <= cctd_attr_s'(RST_ZERO);
      bases_r <= RST_ZERO[23:0];
      basel_r <= RST_ZERO[23:0];
      creg_r  <= RST_ZERO[15:0];
    end
    else
    begin
      if (hit_mm) mm_r <= (mm_r & ~wmask[7:0]) | wdat[7:0];
      if (hit_lc) loc_r <= (loc_r & ~wmask[3:0]) | wdat[3:0];
      if (hit_op) opc_r <= (opc_r & ~wmask[15:0]) | wdat[15:0];
      if (hit_ad) addr_r <= (addr_r & ~wmask[23:0]) | wdat[23:0];
      if (hit_at) attr_r <= cctd_attr_s'((32'(attr_r) & ~wmask) | wdat);
      if (hit_bs) bases_r <= (bases_r & ~wmask[23:0]) | wdat[23:0];
      if (hit_bl) basel_r <= (basel_r & ~wmask[23:0]) | wdat[23:0];
      if (hit_cr) creg_r <= (creg_r & ~wmask[15:0]) | wdat[15:0];
    end
  end

  // Pins and suspend come from outside, two stages each
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pins_m_r <= 8'h00;
      pins_s_r <= 8'h00;
      susp_m_r <= 1'b0;
      susp_s_r <= 1'b0;
    end
    else
    begin
      pins_m_r <= pins_i;
      pins_s_r <= pins_m_r;
      susp_m_r <= suspend_i;
      susp_s_r <= susp_m_r;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (issue)
          state_nxt = pin_op ? ST_PIN1 : ST_RUN;
      ST_PIN1:
        state_nxt = ST_PIN2;
      ST_PIN2:
        state_nxt = ST_RUN;
      ST_RUN:
        if (~susp_s_r && remain_r == 18'h1)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  wire finish = (state_r == ST_RUN) & ~susp_s_r & (remain_r == 18'h1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r       <= ST_IDLE;
      total_r       <= 18'h0;
      remain_r      <= 18'h0;
      prev_branch_r <= 1'b1;
      pin_acc_r     <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (issue)
      begin
        total_r       <= total;
        remain_r      <= total;
        prev_branch_r <= attr_r.branch;
        pin_acc_r     <= dec.pin_acc;
      end
      else if (state_r == ST_RUN && ~susp_s_r)
        remain_r <= remain_r - 18'h1;
    end
  end

  // Pin check: two reads one cycle apart, compared bit by bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      samp1_r <= 8'h00;
      zero_r  <= 1'b0;
      acc_r   <= 8'h00;
    end
    else
    begin
      if (state_r == ST_PIN1)
        samp1_r <= pins_s_r;
      if (state_r == ST_PIN2)
        zero_r <= (pin_x == 8'h00);
      if (state_r == ST_PIN2 && pin_acc_r)
        acc_r <= pin_x;
    end
  end

  // Bank takes effect for the instructions that follow
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bank_r  <= 3'h0;
      alt_r   <= 1'b0;
      inten_r <= 1'b0;
      done_r  <= 1'b0;
    end
    else
    begin
      if (issue && (dec.rbsel || dec.alternate_set_variant))
      begin
        bank_r <= dec.bank;
        alt_r  <= dec.alternate_set_variant;
      end
      else if (issue && dec.swap_register_set_op)
        alt_r <= ~alt_r;
      if (issue && dec.ints_on)
        inten_r <= 1'b1;
      else if (issue && dec.ints_off)
        inten_r <= 1'b0;
      // Completion wins over a clear in the same cycle
      done_r <= finish | (done_r & ~clr_done);
    end
  end

  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = dat_r;
  assign bank_o       = bank_r;
  assign alt_set_o    = alt_r;
  assign zero_flag_o  = zero_r;
  assign acc_o        = acc_r;
  assign busy_o       = ~state_r[0];
  assign done_o       = done_r;
  assign int_enable_o = inten_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ROM_SLOW: assert property (
    (is_rom & ~mm_r[MM_FAST_BIT] & ~is_fast_internal_ram) |-> (base == base_tab[23:16]))
    else $error("ROM read used fast count with fetch bit clear");
  AST_FAST_INTERNAL_RAM_PAGE0: assert property (
    (loc_r == PAGE_LOW & ~attr_r.sfr & addr_r == IRAM0_HI) |-> is_fast_internal_ram)
    else $error("Top of low fast RAM window not classed fast");
  AST_WORD_PEN: assert property (
    (is_word & col_gen & attr_r.bus8) |-> (raw == 18'(base) + 18'(nterm) + 18'(attr_r.waits) + 18'h4))
    else $error("Word penalty on narrow bus not four clocks");
  AST_STACK_COEF: assert property (
    (attr_r.nclass == NC_STACK & is_word & odd) |-> (coef == {1'b0, attr_r.coef} + 9'h4))
    else $error("Odd stack coefficient not raised by four");
  AST_LONG_ENC: assert property (
    attr_r.long_enc |-> (base_tab == basel_r))
    else $error("Long encoding did not use long counts");
  AST_SUSPEND: assert property (
    (state_r == ST_RUN & susp_s_r) |=> ($stable(remain_r) && state_r == ST_RUN))
    else $error("Count moved while suspended");
  AST_FINISH: assert property (
    finish |=> (done_o && idle))
    else $error("Completion did not raise done and return idle");
  AST_PIN_ZERO: assert property (
    (state_r == ST_PIN2 & pin_x == 8'h00) |=> zero_flag_o)
    else $error("Equal pin reads did not set zero flag");
  AST_PIN_ACC: assert property (
    (state_r == ST_PIN2 & pin_acc_r) |=> (acc_o == $past(pin_x)))
    else $error("Accumulator check did not store xor");
  AST_BANK: assert property (
    (issue & dec.rbsel) |=> (bank_o == $past(opc_r[2:0]) && !alt_set_o))
    else $error("Bank select did not load bank");
  AST_ALT: assert property (
    (issue & dec.alternate_set_variant) |=> (alt_set_o && bank_o == $past(opc_r[2:0])))
    else $error("Alternate bank select did not set alt");
  AST_PIN_SEQ: assert property (
    (issue & pin_op) |=> (state_r == ST_PIN1) ##1 (state_r == ST_PIN2) ##1 (state_r == ST_RUN))
    else $error("Pin check did not read twice before running");

  COV_PIN_ACC: cover property ((state_r == ST_PIN2) && pin_acc_r);
  COV_BANK:    cover property (issue && dec.alternate_set_variant);
  COV_SUSPEND: cover property ((state_r == ST_RUN) && susp_s_r ##1 finish);
  COV_DONE:    cover property (finish && clr_done);
  COV_STRING:  cover property (issue && dec.strop);

endmodule : cctd_top

/* File: tb/cctd_pin_model.sv */
`timescale 1ns/1ps
module cctd_pin_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       toggle_i,
  input  wire logic       hold_i,
  input  wire logic [7:0] base_i,
  output logic [7:0]      pins_o,
  output logic            suspend_o
);
  // Inverting every cycle makes two back-to-back pin samples differ in every bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !toggle_i)
      pins_o <= base_i;
    else
      pins_o <= ~pins_o;
  end
  // An interrupt or macro service holding the CPU, as commanded by the bench
  assign suspend_o = hold_i;
endmodule : cctd_pin_model

/* File: tb/test_cctd_top.sv */
`timescale 1ns/1ps
module test_cctd_top;
  import cctd_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        tog = 1'b0;
  logic        hold = 1'b0;
  logic [7:0]  pbase = 8'h00;
  logic [31:0] rdat;
  logic [7:0]  pins, acc;
  logic [2:0]  bank;
  logic        ack, susp, altf, zf, busy, done, inten;
  logic [31:0] expq[$];
  logic [31:0] mskq[$];
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          bcnt = 0;
  integer      seed = 32'hb5303f11;
  // Earlier bank and pin issues leave the previous-branch flag clear
  logic        pb = 1'b0;

  always #2 clk_i = ~clk_i;

  cctd_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pins_i(pins), .suspend_i(susp), .bank_o(bank), .alt_set_o(altf), .zero_flag_o(zf),
    .acc_o(acc), .busy_o(busy), .done_o(done), .int_enable_o(inten));
  cctd_pin_model pm_u (.clk_i(clk_i), .rst_i(rst_i), .toggle_i(tog), .hold_i(hold),
    .base_i(pbase), .pins_o(pins), .suspend_o(susp));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Read data is judged here, against the oldest note left by the driver
  always @(posedge clk_i)
  begin
    cycles++;
    if (busy === 1'b1)
      bcnt++;
    if (ack === 1'b1 && cyc && !we)
      chk($sformatf("reg %h", adr), rdat & mskq.pop_front(), expq.pop_front());
    if (cycles == 60000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1)
      chk("bus ack timeout", {31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expq.push_back(e & m);
    mskq.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask : rd

  task automatic waitidle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (busy !== 1'b0)
      chk("busy timeout", {31'h0, busy}, 32'h0);
  endtask : waitidle

  // Done is cleared first so that every later status read sees this run only
  task automatic issue;
    wr(OFF_STAT, 32'h2);
    bcnt = 0;
    wr(OFF_CTRL, 32'h1);
    waitidle();
  endtask : issue

  function automatic int exp_total(cctd_attr_s t, logic [23:0] a, logic [3:0] pg, logic fast,
                                   logic [23:0] bs, logic [15:0] cr, logic pbr);
    int col;
    int tot;
    logic win;
    win = (pg == PAGE_LOW && a >= IRAM0_LO && a <= IRAM0_HI) || (pg == PAGE_HIGH && a >= IRAMF_LO && a <= IRAMF_HI);
    col = t.sfr ? 2 : win ? 1 : (a < ROM_TOP && fast) ? 0 : 2;
    tot = bs[col*8 +: 8] + t.waits;
    if ((t.size == SZ_WORD || t.size == SZ_TRIPLE) && col == 2 && (t.bus8 || a[0]))
      tot += 4;
    if (t.size == SZ_WORD && col == 0 && a[0])
      tot += 4;
    tot += (t.coef + ((t.nclass == NC_STACK && t.size == SZ_WORD && a[0]) ? 4 : 0))
           * (t.nclass == NC_CREG ? cr[7:0] : t.operand);
    if (!pbr)
      tot -= cr[15:8];
    return (tot < 1) ? 1 : tot;
  endfunction : exp_total

  initial
  begin
    cctd_attr_s  t;
    logic [23:0] atab[6];
    logic [3:0]  ptab[3];
    logic [23:0] a, bs, bl;
    logic [15:0] cr;
    logic [3:0]  pg;
    logic        fast;
    int          et;
    atab = '{24'h000100, 24'h000101, 24'h00fd02, 24'h00fe03, 24'h0ffd04, 24'h030005};
    ptab = '{PAGE_LOW, PAGE_HIGH, 4'h3};
    pbase <= $random(seed);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFF_MM, {24'h0, RST_MM}, 32'hffffffff);
    rd(OFF_STAT, RST_ZERO, 32'hffffffff);
    wr(8'hf0, 32'hffffffff);
    rd(8'hf0, 32'h0, 32'hffffffff);
    $display("test reset values done");
    wr(OFF_ATTR, 32'h0);
    wr(OFF_BASES, 32'h00030303);
    wr(OFF_CREG, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      wr(OFF_OPC, {16'h0, OP_SELBANK, (i[3] ? SEL_ALT : SEL_MAIN), i[2:0]});
      issue();
      chk("bank port", {29'h0, bank}, {29'h0, i[2:0]});
      rd(OFF_STAT, {25'h0, i[2:0], i[3], 3'b010}, 32'h0000007f);
    end
    // Interrupt on, interrupt off, then swap of the register set
    for (int i = 0; i < 3; i++)
    begin
      wr(OFF_OPC, {16'h0, (i == 0) ? OP_INT_ON : (i == 1) ? OP_INT_OFF : OP_SELBANK, (i == 2) ? OP_SWAPSET : 8'h00});
      issue();
      chk("int enable", {31'h0, inten}, {31'h0, i == 0});
      chk("alt port", {31'h0, altf}, {31'h0, i != 2});
      chk("done port", {31'h0, done}, 32'h1);
    end
    $display("test bank select done");
    for (int i = 0; i < 3; i++)
    begin
      tog <= (i == 1);
      wr(OFF_OPC, {16'h0, OP_PREFIX7, (i == 2) ? OP_PINCHK : OP_PINACC});
      issue();
      rd(OFF_STAT, (i == 0) ? 32'h6 : (i == 1) ? 32'hff02 : 32'hff06, 32'hff07);
      chk("acc port", {24'h0, acc}, (i == 0) ? 32'h0 : 32'hff);
      chk("zero port", {31'h0, zf}, {31'h0, i != 1});
    end
    $display("test pin check done");
    for (int k = 0; k < 40; k++)
    begin
      t = $random(seed);
      t.coef = {5'h0, t.coef[2:0]};
      t.operand = {4'h0, t.operand[3:0]};
      t.waits = {4'h0, t.waits[3:0]};
      a = atab[$unsigned($random(seed)) % 6];
      pg = ptab[$unsigned($random(seed)) % 3];
      fast = $random(seed);
      bs = $random(seed);
      bl = $random(seed);
      cr = $random(seed) & 16'h0f0f;
      wr(OFF_MM, {24'h0, fast, 7'h0});
      wr(OFF_LOC, {28'h0, pg});
      wr(OFF_ADDR, {8'h0, a});
      wr(OFF_ATTR, t);
      wr(OFF_BASES, {8'h0, bs});
      wr(OFF_BASEL, {8'h0, bl});
      wr(OFF_CREG, {16'h0, cr});
      wr(OFF_OPC, {16'h0, OP_STRING, 8'h00});
      et = exp_total(t, a, pg, fast, t.long_enc ? bl : bs, cr, pb);
      pb = t.branch;
      issue();
      rd(OFF_TOTAL, et, 32'h0003ffff);
      chk("run length", bcnt, et);
    end
    $display("test timing done");
    wr(OFF_ATTR, 32'h00080010);
    wr(OFF_CREG, 32'h0008);
    wr(OFF_BASES, 32'h00101010);
    // Equal columns keep the count fixed while the top of the low fast window is classed
    wr(OFF_LOC, 32'h0);
    wr(OFF_ADDR, {8'h0, IRAM0_HI});
    wr(OFF_STAT, 32'h2);
    bcnt = 0;
    wr(OFF_CTRL, 32'h1);
    repeat (10) @(posedge clk_i);
    hold <= 1'b1;
    wr(OFF_OPC, {16'h0, OP_SELBANK, SEL_MAIN, 3'h3});
    wr(OFF_CTRL, 32'h1);
    repeat (14) @(posedge clk_i);
    hold <= 1'b0;
    waitidle();
    chk("suspended run", {31'h0, bcnt >= 96 && bcnt <= 104}, 32'h1);
    chk("bank kept", {29'h0, bank}, 32'h7);
    $display("test suspension done");
    give_verdict();
  end
endmodule : test_cctd_top
